// ==== src/rtsp_top.sv ====
// Purpose: real-time trace status port of the debug module
// Assumes: core gives one pipeline event per cycle plus captured values
// Notes:   nibble stream buffered in a 32-entry FIFO before the port
`timescale 1ns/100ps
module rtsp_top
   import rtsp_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        NRST,
   input  wire rtsp_ev_t    EVENT,
   input  wire logic        CAP_OPERAND_EN,
   input  wire logic        CAP_BRANCH_EN,
   input  wire logic        CAP_VALID,
   input  wire rtsp_cap_t   CAP,
   input  wire logic        CAP2_VALID,
   input  wire rtsp_cap_t   CAP2,
   input  wire logic        WDD_VALID,
   input  wire rtsp_cap_t   WDD,
   input  wire logic        BR_VALID,
   input  wire rtsp_cap_t   BR,
   output logic             CORE_STALL,
   output logic [7:0]       TRACE_PORT,
   output logic             TRACE_SAMPLE_CLOCK
);

   ////////////////////////////////////////////////////////////////////////////
   // capture selection and 4-entry word FIFO

   logic                  cap_a_v;
   logic                  cap_b_v;
   rtsp_cap_t             cap_a;
   logic [2:0]            wlevel;
   logic                  wf_in_ready;
   logic                  wf_out_valid;
   logic                  wf_pop;
   logic                  wf_in_valid;
   rtsp_cap_t             wf_out;
   logic                  hold_b;
   rtsp_cap_t             held;

   // write-debug-data bypasses the enables; operands and targets follow config
   always_comb begin
      cap_a_v = 1'b0;
      cap_b_v = 1'b0;
      cap_a   = CAP;
      if (WDD_VALID) begin
         cap_a_v = 1'b1;
         cap_a   = WDD;
      end else if (BR_VALID && CAP_BRANCH_EN) begin
         cap_a_v = 1'b1;
         cap_a   = BR;
      end else if (CAP_VALID && CAP_OPERAND_EN) begin
         cap_a_v = 1'b1;
         cap_b_v = CAP2_VALID;
      end
   end

   // second value of a read-modify-write waits one cycle in a holding slot
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         hold_b <= 1'b0;
         held   <= '0;
      end else if (hold_b && wf_in_ready) begin
         hold_b <= 1'b0;
      end else if (cap_b_v && !CORE_STALL) begin
         hold_b <= 1'b1;
         held   <= CAP2;
      end
   end

   // only a dual capture stalls: against three full entries until two free, and for the cycle its second value is held
   assign CORE_STALL = (cap_b_v && (wlevel >= 3'(FIFO_STALL_LVL))) || hold_b;
   assign wf_in_valid = hold_b || (cap_a_v && !CORE_STALL);

   rtsp_fifo #(.W($bits(rtsp_cap_t)), .D(FIFO_DEPTH)) u_words (
      .clk       (CLOCK),
      .nrst      (NRST),
      .in_valid  (wf_in_valid),
      .in_ready  (wf_in_ready),
      .in_data   (hold_b ? held : cap_a),
      .out_valid (wf_out_valid),
      .out_ready (wf_pop),
      .out_data  (wf_out),
      .level     (wlevel)
   );

   ////////////////////////////////////////////////////////////////////////////
   // nibble sequencer

   typedef enum logic [1:0] {S_STATUS, S_MARK, S_DATA} rtsp_seq_t;

   rtsp_seq_t   seq;
   rtsp_seq_t   next_seq;
   logic [3:0]  status;
   logic [3:0]  nib;
   logic        nib_valid;
   logic        nf_in_ready;
   logic [2:0]  ncnt;
   logic [2:0]  nlast;
   logic        nf_out_valid;
   logic        nf_out_ready;
   logic [3:0]  nf_out;

   // status derived from pipeline event only, never from bus state
   always_comb begin
      case (EVENT)
         EV_CONT:   status = ST_CONTINUE;
         EV_ONE:    status = ST_ONE;
         EV_TWO:    status = ST_TWO;
         EV_USER:   status = ST_USER;
         EV_PULSE:  status = ST_PULSE_WDD;
         EV_WRITE_DEBUG_DATA_INSTR: status = ST_PULSE_WDD;
         EV_BRANCH: status = ST_BRANCH;
         default:   status = ST_CONTINUE;
      endcase
   end

   assign nlast = {wf_out.size, 1'b1};

   // marker and data run back to back; status nibbles only between transfers
   always_comb begin
      next_seq  = seq;
      nib       = status;
      nib_valid = 1'b1;
      wf_pop    = 1'b0;
      case (seq)
         S_STATUS: begin
            // a word taken this cycle gets its marker right after this status
            if (wf_out_valid || wf_in_valid) begin
               next_seq = S_MARK;
            end
         end
         S_MARK: begin
            nib = MARK_1BYTE + {2'b00, wf_out.size};
            if (nf_in_ready) begin
               next_seq = S_DATA;
            end
         end
         S_DATA: begin
            nib = wf_out.data[ncnt*NIB_W +: NIB_W];
            if (nf_in_ready && ncnt == nlast) begin
               wf_pop   = 1'b1;
               next_seq = S_STATUS;
            end
         end
         default: begin
            next_seq = S_STATUS;
         end
      endcase
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         seq <= S_STATUS;
      end else begin
         seq <= next_seq;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         ncnt <= '0;
      end else if (seq != S_DATA) begin
         ncnt <= '0;
      end else if (nf_in_ready) begin
         ncnt <= ncnt + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // nibble FIFO and port packing

   // nibble fifo drains one per cycle; full only absorbs a status burst, ever dropped as idle
   rtsp_fifo #(.W(NIB_W), .D(OUT_FIFO_DEPTH)) u_nibs (
      .clk       (CLOCK),
      .nrst      (NRST),
      .in_valid  (nib_valid),
      .in_ready  (nf_in_ready),
      .in_data   (nib),
      .out_valid (nf_out_valid),
      .out_ready (nf_out_ready),
      .out_data  (nf_out),
      .level     ()
   );

   rtsp_pair u_pair (
      .clk       (CLOCK),
      .nrst      (NRST),
      .nib_valid (nf_out_valid),
      .nib_ready (nf_out_ready),
      .nib       (nf_out),
      .port      (TRACE_PORT),
      .sclk      (TRACE_SAMPLE_CLOCK)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks

   property p_mark_then_data;
      @(posedge CLOCK) disable iff (!NRST)
      (seq == S_MARK && nf_in_ready) |=> seq == S_DATA;
   endproperty
   a_mark_then_data: assert property (p_mark_then_data)
      else $error("marker not followed by data");

   property p_data_contig;
      @(posedge CLOCK) disable iff (!NRST)
      (seq == S_DATA && nf_in_ready && ncnt != nlast) |=> seq == S_DATA;
   endproperty
   a_data_contig: assert property (p_data_contig)
      else $error("data transfer interrupted");

   // longword length counted in clock edges, not by the sequencer's own counter
   property p_long_len;
      @(posedge CLOCK) disable iff (!NRST)
      (seq == S_MARK && nf_in_ready && wf_out.size == 2'h3)
         |=> (seq == S_DATA) [*8] ##1 seq == S_STATUS;
   endproperty
   a_long_len: assert property (p_long_len)
      else $error("wrong data length");

   // a held second value drains at once, so the stall ends with it
   property p_stall_cause;
      @(posedge CLOCK) disable iff (!NRST)
      hold_b |=> !hold_b;
   endproperty
   a_stall_cause: assert property (p_stall_cause)
      else $error("hold slot not drained");

   property p_no_stall_single;
      @(posedge CLOCK) disable iff (!NRST)
      (!cap_b_v && !hold_b) |-> !CORE_STALL;
   endproperty
   a_no_stall_single: assert property (p_no_stall_single)
      else $error("single capture stalled core");

   property p_wdd_always;
      @(posedge CLOCK) disable iff (!NRST)
      (WDD_VALID && !CORE_STALL) |=> wlevel != 3'h0 || $past(wf_pop);
   endproperty
   a_wdd_always: assert property (p_wdd_always)
      else $error("write-debug-data dropped");

   property p_wdd_marker;
      @(posedge CLOCK) disable iff (!NRST)
      (WDD_VALID && !CORE_STALL && seq == S_STATUS && !wf_out_valid)
         |=> seq == S_MARK && nib == MARK_1BYTE + {2'b00, $past(WDD.size)};
   endproperty
   a_wdd_marker: assert property (p_wdd_marker)
      else $error("write-debug-data marker missing");

   property p_cap_gate;
      @(posedge CLOCK) disable iff (!NRST)
      (!WDD_VALID && !BR_VALID && !CAP_OPERAND_EN) |-> !cap_a_v;
   endproperty
   a_cap_gate: assert property (p_cap_gate)
      else $error("operand captured while disabled");

   property p_status_one;
      @(posedge CLOCK) disable iff (!NRST)
      (EVENT == EV_ONE && seq == S_STATUS) |-> nib == ST_ONE;
   endproperty
   a_status_one: assert property (p_status_one)
      else $error("status 1 missing");

   property p_status_cont;
      @(posedge CLOCK) disable iff (!NRST)
      (EVENT == EV_CONT && seq == S_STATUS) |-> nib == ST_CONTINUE;
   endproperty
   a_status_cont: assert property (p_status_cont)
      else $error("continue code missing");

   property p_status_two;
      @(posedge CLOCK) disable iff (!NRST)
      (EVENT == EV_TWO && seq == S_STATUS) |-> nib == ST_TWO;
   endproperty
   a_status_two: assert property (p_status_two)
      else $error("status 2 missing");

   property p_status_user;
      @(posedge CLOCK) disable iff (!NRST)
      (EVENT == EV_USER && seq == S_STATUS) |-> nib == ST_USER;
   endproperty
   a_status_user: assert property (p_status_user)
      else $error("status 3 missing");

   property p_status_pulse;
      @(posedge CLOCK) disable iff (!NRST)
      (EVENT == EV_PULSE && seq == S_STATUS) |-> nib == ST_PULSE_WDD;
   endproperty
   a_status_pulse: assert property (p_status_pulse)
      else $error("status 4 missing");

   c_long: cover property (@(posedge CLOCK) disable iff (!NRST)
      seq == S_DATA && wf_out.size == 2'h3 && wf_pop);
   c_stall: cover property (@(posedge CLOCK) disable iff (!NRST) CORE_STALL);
   c_wdd: cover property (@(posedge CLOCK) disable iff (!NRST) WDD_VALID && !CORE_STALL);
   c_branch: cover property (@(posedge CLOCK) disable iff (!NRST) BR_VALID && CAP_BRANCH_EN);

endmodule : rtsp_top

// ==== src/rtsp_pkg.sv ====
// Purpose: shared constants and carriers for the real-time trace status port
// Assumes: one processor clock, 50 MHz
// Notes:   status codes and size markers are 4-bit trace values
package rtsp_pkg;

   localparam int          CLK_FREQ_HZ   = 50000000;
   localparam int          NIB_W         = 4;
   localparam int          WORD_W        = 32;
   localparam int          FIFO_DEPTH    = 4;
   localparam int          OUT_FIFO_DEPTH = 32;
   localparam int          FIFO_STALL_LVL = 3;
   localparam int          NIBS_PER_WORD = 8;

   localparam logic [3:0]  ST_CONTINUE   = 4'h0;
   localparam logic [3:0]  ST_ONE        = 4'h1;
   localparam logic [3:0]  ST_TWO        = 4'h2;
   localparam logic [3:0]  ST_USER       = 4'h3;
   localparam logic [3:0]  ST_PULSE_WDD  = 4'h4;
   localparam logic [3:0]  ST_BRANCH     = 4'h5;
   localparam logic [3:0]  MARK_1BYTE    = 4'h8;

   localparam logic [7:0]  PORT_RESET    = 8'h00;
   localparam logic [3:0]  NIB_RESET     = 4'h0;

   // pipeline event presented by the core each processor cycle
   typedef enum logic [2:0] {
      EV_CONT,
      EV_ONE,
      EV_TWO,
      EV_USER,
      EV_PULSE,
      EV_WRITE_DEBUG_DATA_INSTR,
      EV_BRANCH
   } rtsp_ev_t;

   // captured operand or target with its length in bytes minus one
   typedef struct packed {
      logic [31:0] data;
      logic [1:0]  size;
   } rtsp_cap_t;

endpackage : rtsp_pkg

// ==== src/rtsp_fifo.sv ====
// Purpose: generic valid/ready FIFO
// Assumes: synchronous to CLOCK, reset NRST active low
// Notes:   full and empty come straight from the fill count
`timescale 1ns/100ps
module rtsp_fifo #(
   parameter int W = 4,
   parameter int D = 32
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data,
   output logic [$clog2(D):0] level
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;

   logic [W-1:0]  mem [D];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic          push;
   logic          pop;

   assign in_ready  = (level != D[$clog2(D):0]);
   assign out_valid = (level != '0);
   assign out_data  = mem[rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wp    <= '0;
         rp    <= '0;
         level <= '0;
      end else begin
         if (push) begin
            wp <= (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
         end
         if (pop) begin
            rp <= (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
         end
         if (push && !pop) begin
            level <= level + 1'b1;
         end else if (pop && !push) begin
            level <= level - 1'b1;
         end
      end
   end

endmodule : rtsp_fifo

// ==== src/rtsp_pair.sv ====
// Purpose: pack two trace nibbles into a byte held for two cycles
// Assumes: nibble stream is drained one value per cycle
// Notes:   inserts continue code when the stream is empty
`timescale 1ns/100ps
module rtsp_pair
   import rtsp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       nib_valid,
   output logic            nib_ready,
   input  wire logic [3:0] nib,
   output logic [7:0]      port,
   output logic            sclk
);
   logic       phase;
   logic [3:0] first;

   assign nib_ready = 1'b1;

   // phase 0 takes the earlier value, phase 1 the later and updates the byte
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase <= 1'b0;
         first <= NIB_RESET;
         port  <= PORT_RESET;
      end else begin
         phase <= ~phase;
         if (!phase) begin
            first <= nib_valid ? nib : ST_CONTINUE;
         end else begin
            port <= {first, nib_valid ? nib : ST_CONTINUE};
         end
      end
   end

   // low while the byte moves, high one cycle later: the rise lands mid window
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sclk <= 1'b0;
      end else begin
         sclk <= ~phase;
      end
   end

   // the byte only moves at edges where phase was high, so it holds into those edges
   property p_port_hold;
      @(posedge clk) disable iff (!nrst)
      phase |-> $stable(port);
   endproperty
   a_port_hold: assert property (p_port_hold)
      else $error("trace byte changed mid window");

   property p_sclk_mid;
      @(posedge clk) disable iff (!nrst)
      $rose(sclk) |-> $stable(port);
   endproperty
   a_sclk_mid: assert property (p_sclk_mid)
      else $error("sample clock edge not mid window");

endmodule : rtsp_pair

// ==== tb/rtsp_sampler.sv ====
// Purpose: emulator side that samples the trace port
// Assumes: each byte is taken on the low phase after the sample clock rises
// Notes:   bad counts phase slips; first two cycles after reset are not judged
`timescale 1ns/100ps
module rtsp_sampler (
   input  wire logic       CLOCK,
   input  wire logic       NRST,
   input  wire logic [7:0] TRACE_PORT,
   input  wire logic       TRACE_SAMPLE_CLOCK
);
   logic [3:0] stream[$];
   int         bad = 0;
   int         warm;
   logic       prev_clk;
   logic [7:0] prev_port;
   ////////////////////////////////////////////////////////////////////////////
   always @(negedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         warm = 0;
         prev_clk = 1'b0;
         prev_port = 8'h00;
      end else begin
         if (warm > 1 && TRACE_SAMPLE_CLOCK === prev_clk) bad++;
         // the byte may only move in the phase where the sample clock just fell
         if (warm > 1 && TRACE_PORT !== prev_port && TRACE_SAMPLE_CLOCK !== 1'b0) bad++;
         if (TRACE_SAMPLE_CLOCK === 1'b1 && prev_clk === 1'b0) begin
            stream.push_back(TRACE_PORT[7:4]);
            stream.push_back(TRACE_PORT[3:0]);
         end
         prev_clk = TRACE_SAMPLE_CLOCK;
         prev_port = TRACE_PORT;
         warm++;
      end
   end
endmodule : rtsp_sampler

// ==== tb/testbench.sv ====
// Purpose: self-checking bench of the trace status port
// Assumes: status and data seen only as the nibble stream at the far side
// Notes:   idle fill between words is allowed, so each word is sought alone
`timescale 1ns/100ps
module testbench
   import rtsp_pkg::*;
;
   logic       CLOCK, NRST, CAP_OPERAND_EN, CAP_BRANCH_EN;
   logic       CAP_VALID, CAP2_VALID, WDD_VALID, BR_VALID, CORE_STALL;
   rtsp_ev_t   EVENT;
   rtsp_cap_t  CAP, CAP2, WDD, BR;
   logic [7:0] TRACE_PORT;
   logic       TRACE_SAMPLE_CLOCK;
   int         err_total = 0;
   int         total_checks = 0;
   ////////////////////////////////////////////////////////////////////////////
   rtsp_top dut (.CLOCK(CLOCK), .NRST(NRST), .EVENT(EVENT), .CAP_OPERAND_EN(CAP_OPERAND_EN),
      .CAP_BRANCH_EN(CAP_BRANCH_EN), .CAP_VALID(CAP_VALID), .CAP(CAP),
      .CAP2_VALID(CAP2_VALID), .CAP2(CAP2), .WDD_VALID(WDD_VALID), .WDD(WDD),
      .BR_VALID(BR_VALID), .BR(BR), .CORE_STALL(CORE_STALL), .TRACE_PORT(TRACE_PORT),
      .TRACE_SAMPLE_CLOCK(TRACE_SAMPLE_CLOCK));
   rtsp_sampler u_smp (.CLOCK(CLOCK), .NRST(NRST), .TRACE_PORT(TRACE_PORT),
      .TRACE_SAMPLE_CLOCK(TRACE_SAMPLE_CLOCK));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t %s", $time, msg);
      end
   endtask : check
   function automatic logic has_seq(input logic [3:0] q[$]);
      logic ok;
      for (int i = 0; i + q.size() <= u_smp.stream.size(); i++) begin
         ok = 1'b1;
         foreach (q[j]) if (u_smp.stream[i+j] !== q[j]) ok = 1'b0;
         if (ok) return 1'b1;
      end
      return 1'b0;
   endfunction : has_seq
   // bounded wait on the stream itself, the port has no completion flag
   task automatic wait_seq(input logic [3:0] q[$], input string msg);
      int n;
      n = 0;
      while (!has_seq(q) && n < 300) begin
         @(posedge CLOCK);
         n++;
      end
      check(has_seq(q), 1'b1, msg);
   endtask : wait_seq
   task automatic add_word(inout logic [3:0] q[$], input rtsp_cap_t c);
      q.push_back(MARK_1BYTE | {2'h0, c.size});
      for (int i = 0; i < 2 * c.size + 2; i++) q.push_back(c.data[4*i +: 4]);
   endtask : add_word
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_status();
      rtsp_ev_t   evs[6] = '{EV_ONE, EV_CONT, EV_TWO, EV_USER, EV_PULSE, EV_BRANCH};
      logic [3:0] q[$] = '{ST_ONE, ST_CONTINUE, ST_TWO, ST_USER, ST_PULSE_WDD, ST_BRANCH};
      foreach (evs[i]) begin
         @(posedge CLOCK);
         EVENT <= evs[i];
      end
      @(posedge CLOCK);
      EVENT <= EV_CONT;
      wait_seq(q, "status codes");
      $display("test status done");
   endtask : t_status
   task automatic t_load();
      logic [3:0] q[$] = '{ST_ONE};
      rtsp_cap_t  c = '{32'h87654321, 2'h3};
      add_word(q, c);
      @(posedge CLOCK);
      CAP_OPERAND_EN <= 1'b1;
      EVENT <= EV_ONE;
      CAP_VALID <= 1'b1;
      CAP <= c;
      @(posedge CLOCK);
      CAP_VALID <= 1'b0;
      EVENT <= EV_CONT;
      wait_seq(q, "load longword");
      $display("test load done");
   endtask : t_load
   task automatic t_wdd();
      logic [3:0] q[$];
      logic [3:0] g[$];
      rtsp_cap_t  c;
      add_word(g, '{32'hfedcba98, 2'h3});
      @(posedge CLOCK);
      CAP_OPERAND_EN <= 1'b0;
      CAP_VALID <= 1'b1;
      CAP <= '{32'hfedcba98, 2'h3};
      for (int s = 0; s < 4; s++) begin
         c = '{32'h13579bdf, 2'(s)};
         q = '{ST_PULSE_WDD};
         add_word(q, c);
         @(posedge CLOCK);
         CAP_VALID <= 1'b0;
         EVENT <= EV_WRITE_DEBUG_DATA_INSTR;
         WDD_VALID <= 1'b1;
         WDD <= c;
         @(posedge CLOCK);
         WDD_VALID <= 1'b0;
         EVENT <= EV_CONT;
         wait_seq(q, "write debug data size");
      end
      check(has_seq(g), 1'b0, "operand shown while capture off");
      $display("test wdd done");
   endtask : t_wdd
   task automatic t_branch();
      logic [3:0] q[$] = '{ST_BRANCH};
      rtsp_cap_t  c = '{32'h2468ace0, 2'h2};
      add_word(q, c);
      @(posedge CLOCK);
      CAP_BRANCH_EN <= 1'b1;
      EVENT <= EV_BRANCH;
      BR_VALID <= 1'b1;
      BR <= c;
      @(posedge CLOCK);
      BR_VALID <= 1'b0;
      EVENT <= EV_CONT;
      wait_seq(q, "branch target");
      $display("test branch done");
   endtask : t_branch
   task automatic t_stall();
      logic [3:0] q[$];
      rtsp_cap_t  w[5];
      int         n;
      foreach (w[i]) w[i] = '{32'h01234567 + i * 32'h11111111, 2'h3};
      @(posedge CLOCK);
      CAP_OPERAND_EN <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         CAP_VALID <= 1'b1;
         CAP <= w[i];
         @(negedge CLOCK);
         check(CORE_STALL, 1'b0, "stall on single capture");
         @(posedge CLOCK);
      end
      CAP2_VALID <= 1'b1;
      CAP <= w[3];
      CAP2 <= w[4];
      @(negedge CLOCK);
      check(CORE_STALL, 1'b1, "no stall on dual capture at three");
      n = 0;
      // the dual offer is held until the edge after the stall lifts
      while (CORE_STALL !== 1'b0 && n < 200) begin
         @(negedge CLOCK);
         n++;
      end
      check(n < 200, 1'b1, "stall never released");
      @(posedge CLOCK);
      CAP_VALID <= 1'b0;
      CAP2_VALID <= 1'b0;
      foreach (w[i]) begin
         q.delete();
         add_word(q, w[i]);
         wait_seq(q, "buffered word");
      end
      $display("test stall done");
   endtask : t_stall
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      CLOCK = 1'b0;
      forever #10 CLOCK = ~CLOCK;
   end
   initial begin
      #(20 * 10000);
      $display("watchdog expired");
      err_total++;
      complete_run();
   end
   initial begin
      NRST = 1'b0;
      EVENT = EV_CONT;
      {CAP_OPERAND_EN, CAP_BRANCH_EN, CAP_VALID, CAP2_VALID, WDD_VALID, BR_VALID} = 6'h00;
      {CAP, CAP2, WDD, BR} = '0;
      repeat (11) @(posedge CLOCK);
      @(negedge CLOCK);
      check(TRACE_PORT, PORT_RESET, "port in reset");
      check(TRACE_SAMPLE_CLOCK, 1'b0, "sample clock in reset");
      check(CORE_STALL, 1'b0, "stall in reset");
      @(posedge CLOCK);
      NRST <= 1'b1;
      t_status();
      t_load();
      t_wdd();
      t_branch();
      t_stall();
      check(u_smp.bad, 32'h0, "port or sample clock phase");
      complete_run();
   end
endmodule : testbench
